// File: verilog/ptai_map.svh
`ifndef PTAI_MAP_SVH
`define PTAI_MAP_SVH

// Bus widths
`define PTAI_DQ_W 32
`define PTAI_HALF_W 16
`define PTAI_BE_W 4
`define PTAI_REGION_W 2

// Reset values of the add-on facing outputs
`define PTAI_ATTN_N_RST 1'h1
`define PTAI_BURST_N_RST 1'h1
`define PTAI_BE_N_RST 4'hF
`define PTAI_REGION_RST 2'h0
`define PTAI_WRITE_RST 1'h0
`define PTAI_IRQ_N_RST 1'h1
`define PTAI_ADDON_RST_N_RST 1'h0
`define PTAI_OE_N_RST 2'h3
`define PTAI_WORD_RST 32'h0000_0000

// Region codes: base address register 1 through 4
`define PTAI_REGION_BAR1 2'h0
`define PTAI_REGION_BAR2 2'h1
`define PTAI_REGION_BAR3 2'h2
`define PTAI_REGION_BAR4 2'h3

`endif

// File: verilog/ptai_pkg.sv
`default_nettype none
`include "ptai_map.svh"

package ptai_pkg;

  typedef enum logic [2:0] {
    PTAI_IDLE = 3'b001,
    PTAI_ATTN = 3'b010,
    PTAI_GAP = 3'b100
  } ptai_state_t;

  typedef logic [`PTAI_DQ_W-1:0] ptai_word_t;
  typedef logic [`PTAI_BE_W-1:0] ptai_be_t;
  typedef logic [`PTAI_REGION_W-1:0] ptai_region_t;

endpackage : ptai_pkg

`default_nettype wire

// File: verilog/ptai_addr_drive.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptai_map.svh"

module ptai_addr_drive (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic addr_req_n,
  input wire logic mode_16,
  input wire ptai_pkg::ptai_word_t addr,
  output logic clk_copy,
  output logic [`PTAI_DQ_W-1:0] dq_out,
  output logic [1:0] dq_oe_n
);
  import ptai_pkg::*;

  typedef struct packed {
    ptai_word_t dq;
    logic [1:0] oe_n;
  } ptai_drv_t;

  ptai_drv_t drv;
  ptai_drv_t next_drv;

  // Add-on clock is the core clock itself, not a divided copy
  assign clk_copy = ref_clk;

  always_comb begin
    next_drv = drv;
    next_drv.oe_n = `PTAI_OE_N_RST;
    next_drv.dq = `PTAI_WORD_RST;
    if (!addr_req_n) begin
      next_drv.dq[`PTAI_HALF_W-1:0] = addr[`PTAI_HALF_W-1:0];
      next_drv.oe_n[0] = 1'h0;
      if (!mode_16) begin
        next_drv.dq[`PTAI_DQ_W-1:`PTAI_HALF_W] = addr[`PTAI_DQ_W-1:`PTAI_HALF_W];
        next_drv.oe_n[1] = 1'h0;
      end
    end
    if (sys_rst) begin
      next_drv.oe_n = `PTAI_OE_N_RST;
      next_drv.dq = `PTAI_WORD_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    drv <= next_drv;
  end

  assign dq_out = drv.dq;
  assign dq_oe_n = drv.oe_n;

endmodule : ptai_addr_drive

`default_nettype wire

// File: verilog/ptai_passthru.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptai_map.svh"

module ptai_passthru (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Request side from the PCI target decoder
  input wire logic pci_req_valid,
  input wire ptai_pkg::ptai_region_t pci_req_region,
  input wire ptai_pkg::ptai_be_t pci_req_be_n,
  input wire logic pci_req_write,
  input wire logic pci_req_burst,
  input wire ptai_pkg::ptai_word_t pci_req_addr,
  output logic pci_req_taken,
  output logic pci_done,
  output ptai_pkg::ptai_word_t pci_rdata,
  input wire logic sw_addon_reset,
  input wire logic addon_event,
  // Add-on side
  output logic passthru_attention_n,
  output logic passthru_burst_n,
  output ptai_pkg::ptai_region_t passthru_region_num,
  output ptai_pkg::ptai_be_t passthru_byte_en_n,
  output logic passthru_write,
  input wire logic passthru_ready_n,
  input wire logic passthru_addr_req_n,
  input wire logic mode_16,
  input wire ptai_pkg::ptai_word_t dq_in,
  output ptai_pkg::ptai_word_t dq_out,
  output logic [1:0] dq_oe_n,
  output logic addon_reset_out_n,
  output logic addon_clock_out,
  output logic addon_irq_n
);
  import ptai_pkg::*;

  typedef struct packed {
    ptai_state_t state;
    logic attn_n;
    logic burst_n;
    ptai_region_t region;
    ptai_be_t be_n;
    logic write;
    ptai_word_t addr;
    logic taken;
    logic done;
    ptai_word_t rdata;
    logic rst_n;
    logic irq_n;
  } ptai_core_t;

  ptai_core_t st;
  ptai_core_t next_st;

  // Reset image of every core field
  function automatic ptai_core_t core_rst_image();
    ptai_core_t c;
    c.state = PTAI_IDLE;
    c.attn_n = `PTAI_ATTN_N_RST;
    c.burst_n = `PTAI_BURST_N_RST;
    c.region = `PTAI_REGION_RST;
    c.be_n = `PTAI_BE_N_RST;
    c.write = `PTAI_WRITE_RST;
    c.addr = `PTAI_WORD_RST;
    c.taken = 1'h0;
    c.done = 1'h0;
    c.rdata = `PTAI_WORD_RST;
    c.rst_n = `PTAI_ADDON_RST_N_RST;
    c.irq_n = `PTAI_IRQ_N_RST;
    return c;
  endfunction : core_rst_image

  // Level copies of reset and event requests toward the add-on
  function automatic ptai_core_t track_levels(
    input ptai_core_t c,
    input logic rst_req,
    input logic sw_rst_req,
    input logic event_req
  );
    ptai_core_t o;
    o = c;
    o.rst_n = !(rst_req || sw_rst_req);
    o.irq_n = !event_req;
    return o;
  endfunction : track_levels

  // Opens a cycle: attention low, request fields frozen
  function automatic ptai_core_t open_cycle(
    input ptai_core_t c,
    input ptai_region_t region,
    input ptai_be_t be_n,
    input logic write,
    input logic burst,
    input ptai_word_t addr
  );
    ptai_core_t o;
    o = c;
    o.state = PTAI_ATTN;
    o.attn_n = 1'h0;
    o.burst_n = !burst;
    o.region = region;
    o.be_n = be_n;
    o.write = write;
    o.addr = addr;
    o.taken = 1'h1;
    return o;
  endfunction : open_cycle

  // Ends a cycle on ready; region, lanes and direction keep their values
  function automatic ptai_core_t close_cycle(
    input ptai_core_t c,
    input ptai_word_t din
  );
    ptai_core_t o;
    o = c;
    o.state = PTAI_GAP;
    o.attn_n = 1'h1;
    o.burst_n = 1'h1;
    o.done = 1'h1;
    if (!c.write) begin
      o.rdata = din;
    end
    return o;
  endfunction : close_cycle

  always_comb begin
    next_st = st;
    next_st.taken = 1'h0;
    next_st.done = 1'h0;
    next_st = track_levels(
      next_st,
      sys_rst,
      sw_addon_reset,
      addon_event
    );
    case (st.state)
      PTAI_IDLE: begin
        if (pci_req_valid) begin
          next_st = open_cycle(
            next_st,
            pci_req_region,
            pci_req_be_n,
            pci_req_write,
            pci_req_burst,
            pci_req_addr
          );
        end
      end
      PTAI_ATTN: begin
        // Fields stay frozen until ready is sampled low
        if (!passthru_ready_n) begin
          next_st = close_cycle(
            next_st,
            dq_in
          );
        end
      end
      PTAI_GAP: begin
        // One idle cycle so attention is seen high between cycles
        next_st.state = PTAI_IDLE;
      end
      default: begin
        next_st.state = PTAI_IDLE;
        next_st.attn_n = 1'h1;
        next_st.burst_n = 1'h1;
      end
    endcase
    if (sys_rst) begin
      next_st = core_rst_image();
    end
  end

  // Core state register
  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  // Registered outputs, PCI side
  assign pci_req_taken = st.taken;
  assign pci_done = st.done;
  assign pci_rdata = st.rdata;

  // Registered outputs, add-on side
  assign passthru_attention_n = st.attn_n;
  assign passthru_burst_n = st.burst_n;
  assign passthru_region_num = st.region;
  assign passthru_byte_en_n = st.be_n;
  assign passthru_write = st.write;
  assign addon_reset_out_n = st.rst_n;
  assign addon_irq_n = st.irq_n;

  // Address drive; bus width chosen by the mode pin
  ptai_addr_drive u_addr_drive (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .addr_req_n(passthru_addr_req_n),
    .mode_16(mode_16),
    .addr(st.addr),
    .clk_copy(addon_clock_out),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );

endmodule : ptai_passthru

`default_nettype wire

// File: sim/ptai_passthru_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ptai_passthru_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pci_req_taken,
  input wire logic pci_done,
  input wire logic passthru_attention_n,
  input wire logic passthru_burst_n,
  input wire logic passthru_ready_n,
  input wire logic passthru_addr_req_n,
  input wire logic mode_16,
  input wire logic [1:0] dq_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_take_attn: assert property (pci_req_taken |-> !passthru_attention_n)
    else $error("no attention on take");
  chk_burst_attn: assert property (!passthru_burst_n |-> !passthru_attention_n)
    else $error("burst outside cycle");
  chk_attn_hold: assert property (!passthru_attention_n && passthru_ready_n
    |=> !passthru_attention_n && !pci_done) else $error("attention dropped early");
  chk_attn_release: assert property (!passthru_attention_n && !passthru_ready_n
    |=> passthru_attention_n && passthru_burst_n && pci_done) else $error("no release");
  chk_attn_gap: assert property (!$past(sys_rst) && $rose(passthru_attention_n)
    |=> passthru_attention_n) else $error("no gap");
  chk_done_cause: assert property (pci_done |-> $past(passthru_attention_n) == 1'b0
    && $past(passthru_ready_n) == 1'b0) else $error("done without ready");
  chk_addr_drive: assert property (!passthru_addr_req_n
    |=> dq_oe_n == {$past(mode_16), 1'b0}) else $error("address not driven");
  chk_addr_idle: assert property (passthru_addr_req_n [*3] |-> dq_oe_n == 2'h3)
    else $error("bus driven when idle");
endmodule : ptai_passthru_properties
bind ptai_passthru ptai_passthru_properties ptai_passthru_properties_i (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .pci_req_taken(pci_req_taken),
  .pci_done(pci_done),
  .passthru_attention_n(passthru_attention_n),
  .passthru_burst_n(passthru_burst_n),
  .passthru_ready_n(passthru_ready_n),
  .passthru_addr_req_n(passthru_addr_req_n),
  .mode_16(mode_16),
  .dq_oe_n(dq_oe_n)
);
`default_nettype wire

// File: sim/ptai_addon_model.sv
`timescale 1ns/100ps
`default_nettype none
module ptai_addon_model (
  input wire logic ref_clk,
  input wire logic attn_n,
  input wire logic areq_n,
  input wire logic [3:0] lat,
  output logic ready_n = 1'b1,
  output ptai_pkg::ptai_word_t dq = 32'h0000_0001
);
  import ptai_pkg::*;
  int n = 0;
  always @(negedge ref_clk) begin
    n = (attn_n || !ready_n) ? 0 : n + 1;
    ready_n <= !(n > lat + 1 && areq_n);
    dq <= {dq[30:0], ~dq[31]};
  end
endmodule : ptai_addon_model
`default_nettype wire

// File: sim/ptai_passthru_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ptai_passthru_tb;
  import ptai_pkg::*;
  logic ref_clk = 0, sys_rst = 1, pci_req_valid = 0, pci_req_write = 0, pci_req_burst = 0;
  logic sw_addon_reset = 0, addon_event = 0, passthru_addr_req_n = 1, mode_16 = 0;
  logic pci_req_taken, pci_done, passthru_attention_n, passthru_burst_n, passthru_write;
  logic passthru_ready_n, addon_reset_out_n, addon_clock_out, addon_irq_n;
  logic [1:0] dq_oe_n;
  logic [3:0] lat = 0;
  ptai_region_t pci_req_region = 0, passthru_region_num;
  ptai_be_t pci_req_be_n = 0, passthru_byte_en_n;
  ptai_word_t pci_req_addr = 0, pci_rdata, dq_in, dq_out, exp_rd, x = 32'h0000_000A;
  int errors = 0, n_tests = 0, k;
  logic [8:0] exp_q[$];
  ptai_passthru ptai_passthru_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pci_req_valid(pci_req_valid),
    .pci_req_region(pci_req_region),
    .pci_req_be_n(pci_req_be_n),
    .pci_req_write(pci_req_write),
    .pci_req_burst(pci_req_burst),
    .pci_req_addr(pci_req_addr),
    .pci_req_taken(pci_req_taken),
    .pci_done(pci_done),
    .pci_rdata(pci_rdata),
    .sw_addon_reset(sw_addon_reset),
    .addon_event(addon_event),
    .passthru_attention_n(passthru_attention_n),
    .passthru_burst_n(passthru_burst_n),
    .passthru_region_num(passthru_region_num),
    .passthru_byte_en_n(passthru_byte_en_n),
    .passthru_write(passthru_write),
    .passthru_ready_n(passthru_ready_n),
    .passthru_addr_req_n(passthru_addr_req_n),
    .mode_16(mode_16),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .addon_reset_out_n(addon_reset_out_n),
    .addon_clock_out(addon_clock_out),
    .addon_irq_n(addon_irq_n)
  );
  ptai_addon_model ptai_addon_model_i (.ref_clk(ref_clk), .attn_n(passthru_attention_n),
    .areq_n(passthru_addr_req_n), .lat(lat), .ready_n(passthru_ready_n), .dq(dq_in));
  function automatic ptai_word_t xs(ptai_word_t v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic cmp(ptai_word_t g, ptai_word_t e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : cmp
  task automatic close_out;
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!passthru_ready_n) exp_rd <= dq_in;
  initial begin
    #20000;
    errors++;
    close_out();
  end
  initial begin
    #6;
    cmp(32'(addon_clock_out), 32'h1);
    #4;
    cmp(32'(addon_clock_out), 32'h0);
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    cmp(32'({passthru_attention_n, dq_oe_n, addon_reset_out_n}), 32'hE);
    sys_rst <= 0;
    for (int i = 0; i < 12; i++) begin
      x = xs(x);
      {addon_event, sw_addon_reset, lat, mode_16, pci_req_burst, pci_req_write, pci_req_be_n,
        pci_req_region} <= x[14:0];
      pci_req_addr <= x;
      exp_q.push_back({1'b0, !x[7], x[1:0], x[5:2], x[6]});
      pci_req_valid <= 1;
      for (k = 0; k < 9 && pci_req_taken !== 1'b1; k++) @(negedge ref_clk);
      cmp(k, i ? 2 : 1);
      pci_req_valid <= 0;
      passthru_addr_req_n <= 0;
      cmp(32'({passthru_attention_n, passthru_burst_n, passthru_region_num, passthru_byte_en_n,
        passthru_write}), 32'(exp_q.pop_front()));
      @(negedge ref_clk);
      cmp(dq_out, mode_16 ? {16'h0000, pci_req_addr[15:0]} : pci_req_addr);
      cmp(32'(dq_oe_n), 32'({mode_16, 1'b0}));
      passthru_addr_req_n <= 1;
      repeat (2) @(negedge ref_clk);
      for (k = 0; k < 24 && pci_done !== 1'b1; k++) @(negedge ref_clk);
      cmp(32'({pci_done, passthru_attention_n, dq_oe_n, addon_reset_out_n, addon_irq_n}),
        32'({4'hF, !sw_addon_reset, !addon_event}));
      if (!pci_req_write) cmp(pci_rdata, exp_rd);
    end
    close_out();
  end
endmodule : ptai_passthru_tb
`default_nettype wire
